// File: hdl/rtccp_top.sv
// Purpose: Control/status register one, interrupt period select and the periodic
//          interrupt generator of a real-time clock, reached over a three-wire link.
// Assumes: Link frames are address nibble, command nibble, data nibble, MSB first,
//          sampled on rising serial clock; the serial clock runs only inside frames.
// Notes:   Alarm comparison lives outside; it hands in its enable and match levels.
//
// Summary of operation
// - Writing adjust bit 1 starts seconds adjust.
// - Busy reads 1 during adjust, bounded.
// - Adjust waits until carry hold returns high.
// - Adjust clears prescaler, zeroes seconds, rounds minutes.
// - Busy reads 1 while counters update.
// - Carry hold low blocks the seconds carry.
// - Chip enable low forces carry hold high.
// - Held carry applied once hold returns high.
// - Halt flag sets on oscillator stop, sticks.
// - Halt flag cannot set while chip enable high.
// - A control write clears halt flag while the oscillator runs.
// - Alarm flag follows enabled alarm match.
// - Output low while periodic or alarm flag reads 1.
// - Top select bit picks pulse or level.
// - Level mode only: flag writes drive output.
// - Pulse mode: off, low, 1024 Hz, 0.5 s.
// - Level mode: second, ten seconds, minute, ten minutes.
// - Level mode: hourly, daily, weekly, monthly.
// - Both registers decode regardless of bank.
`timescale 1ns/100ps
`default_nettype none

module rtccp_top
  import rtccp_pkg::*;
#(
  parameter int HALF_TICK = HALF_TICK_CYC,
  parameter int BUSY_LEN  = BUSY_CYC
) (
  input  wire logic          clock,
  input  wire logic          rstn,
  input  wire logic          serialClock,
  input  wire logic          chipEnable,
  input  wire logic          serialDataIoIn,
  output logic               serialDataIoOut,
  output logic               serialDataIoOeN,
  input  wire logic          oscRunning,
  input  wire logic          alarmEnable,
  input  wire logic          alarmMatch,
  output logic               irqOutN,
  output logic               irqOutNOeN,
  output rtccp_pkg::rtccp_time_t timeNow
);
  import rtccp_pkg::*;

  // ************************************************************
  // Local constants and state carriers
  // ************************************************************
  localparam logic [15:0] PRE_LAST  = 16'(HALF_TICK - 1);
  localparam logic [13:0] BUSY_LOAD = 14'(BUSY_LEN);

  typedef struct packed {
    logic        ceS1;
    logic        ceS2;
    logic        oscS1;
    logic        oscS2;
    logic        tglS1;
    logic        tglS2;
    logic        tglPrev;
    logic [15:0] preCnt;
    logic [10:0] subSec;
    rtccp_time_t tm;
    logic        carryHold;
    logic        adjPend;
    logic        carryPend;
    logic [13:0] busyCnt;
    logic        oscHalt;
    logic        alarmFlag;
    logic        irqFlag;
    logic [3:0]  period;
    logic        irqLow;
  } rtccp_core_t;

  typedef struct packed {
    logic [3:0]  bitCnt;
    logic [10:0] sh;
    logic [3:0]  outSh;
    logic        oe;
    logic [7:0]  st1;
    logic [7:0]  st2;
  } rtccp_frame_t;

  typedef struct packed {
    logic       tgl;
    logic [3:0] addr;
    logic [3:0] data;
  } rtccp_wr_t;

  localparam rtccp_core_t CORE_RST = '{
    ceS1: 1'b0, ceS2: 1'b0, oscS1: 1'b0, oscS2: 1'b0,
    tglS1: 1'b0, tglS2: 1'b0, tglPrev: 1'b0,
    preCnt: 16'h0000, subSec: 11'h000, tm: TIME_RST,
    carryHold: HOLD_RST, adjPend: 1'b0, carryPend: 1'b0,
    busyCnt: 14'h0000, oscHalt: HALT_RST, alarmFlag: 1'b0,
    irqFlag: 1'b0, period: PERIOD_RST, irqLow: 1'b0};

  rtccp_core_t  core;
  rtccp_core_t  next_core;
  rtccp_frame_t frame;
  rtccp_frame_t next_frame;
  rtccp_wr_t    wr;
  rtccp_wr_t    next_wr;

  logic       frameRstN;
  logic [7:0] statusVec;
  logic       counterBusy;

  // ************************************************************
  // Time counter helpers
  // ************************************************************

  // Minute carry ripples through hours, weekday and day of month.
  function automatic rtccp_time_t incMin(input rtccp_time_t t);
    rtccp_time_t r;
    r = t;
    if (t.min == MIN_MAX) begin
      r.min = 6'h00;
      if (t.hour == HOUR_MAX) begin
        r.hour = 5'h00;
        r.wday = (t.wday == WDAY_MAX) ? 3'h0 : t.wday + 3'h1;
        r.mday = (t.mday == MDAY_MAX) ? MDAY_FIRST : t.mday + 5'h01;
      end else begin
        r.hour = t.hour + 5'h01;
      end
    end else begin
      r.min = t.min + 6'h01;
    end
    return r;
  endfunction : incMin

  // One second step.
  function automatic rtccp_time_t incSec(input rtccp_time_t t);
    rtccp_time_t r;
    r = t;
    if (t.sec == SEC_MAX) begin
      r = incMin(t);
      r.sec = 6'h00;
    end else begin
      r.sec = t.sec + 6'h01;
    end
    return r;
  endfunction : incSec

  // Level-mode event test on the freshly stepped time.
  function automatic logic levelHit(input logic [2:0] sel, input rtccp_time_t t);
    logic s0;
    logic m0;
    logic h0;
    s0 = (t.sec == 6'h00);
    m0 = (t.min == 6'h00);
    h0 = (t.hour == 5'h00);
    // Only the low three select bits matter here; the mode bit was tested by the caller.
    case (sel)
      3'h0: levelHit = 1'b1;
      3'h1: levelHit = ((t.sec % TEN) == 6'h00);
      3'h2: levelHit = s0;
      3'h3: levelHit = s0 && ((t.min % TEN) == 6'h00);
      3'h4: levelHit = s0 && m0;
      3'h5: levelHit = s0 && m0 && h0;
      3'h6: levelHit = s0 && m0 && h0 && (t.wday == 3'h0);
      default: levelHit = s0 && m0 && h0 && (t.mday == MDAY_FIRST);
    endcase
  endfunction : levelHit

  // ************************************************************
  // Core domain
  // ************************************************************

  // Edge of the synchronised write toggle marks one completed write.
  logic wrStb;
  logic wrCtrl;
  logic wrPer;
  logic tick;
  logic secCarry;
  logic doAdj;
  logic doCarry;
  logic pulseLow;

  assign wrStb  = core.tglS2 ^ core.tglPrev;
  assign wrCtrl = wrStb && (wr.addr == REG_CTRL1);
  assign wrPer  = wrStb && (wr.addr == REG_PERIOD);
  assign counterBusy = (core.busyCnt != 14'h0000);

  // Pin and toggle synchronisers, prescaler, carry hold and counters.
  always_comb begin
    next_core = core;
    next_core.ceS1    = chipEnable;
    next_core.ceS2    = core.ceS1;
    next_core.oscS1   = oscRunning;
    next_core.oscS2   = core.oscS1;
    next_core.tglS1   = wr.tgl;
    next_core.tglS2   = core.tglS1;
    next_core.tglPrev = core.tglS2;
    tick     = 1'b0;
    secCarry = 1'b0;
    pulseLow = 1'b0;
    // A stopped oscillator freezes the prescaler and so the second carry; busy still counts down.
    if (core.oscS2) begin
      if (core.preCnt == PRE_LAST) begin
        next_core.preCnt = 16'h0000;
        tick = 1'b1;
      end else begin
        next_core.preCnt = core.preCnt + 16'h0001;
      end
    end
    if (tick) begin
      next_core.subSec = core.subSec + 11'h001;
      secCarry = (core.subSec == SUBSEC_LAST);
    end
    if (counterBusy) begin
      next_core.busyCnt = core.busyCnt - 14'h0001;
    end
    // Carry hold is written by software, forced high with chip enable low.
    if (wrCtrl) begin
      next_core.carryHold = wr.data[BIT_HOLD];
    end
    if (!core.ceS2) begin
      next_core.carryHold = 1'b1;
    end
    doAdj   = core.adjPend && core.carryHold;
    doCarry = (secCarry || core.carryPend) && core.carryHold;
    if (doAdj) begin
      // Adjust wins over a carry in the same cycle; it restarts the second anyway.
      next_core.preCnt    = 16'h0000;
      next_core.subSec    = 11'h000;
      next_core.tm        = (core.tm.sec >= SEC_HALF) ? incMin(core.tm) : core.tm;
      next_core.tm.sec    = 6'h00;
      next_core.adjPend   = 1'b0;
      next_core.carryPend = 1'b0;
      next_core.busyCnt   = BUSY_LOAD;
    end else if (doCarry) begin
      next_core.tm        = incSec(core.tm);
      // A fresh carry landing on a held one stays pending for the next cycle, so none is lost.
      next_core.carryPend = secCarry && core.carryPend;
      next_core.busyCnt   = BUSY_LOAD;
    end else if (secCarry) begin
      next_core.carryPend = 1'b1;
    end
    // A new adjust request placed after the clear so it is never lost.
    if (wrCtrl && wr.data[BIT_ADJ]) begin
      next_core.adjPend = 1'b1;
    end
    // Halt flag: clear on control write while the oscillator runs, then a live halt sets it again.
    if (wrCtrl && core.oscS2) begin
      next_core.oscHalt = 1'b0;
    end
    if (!core.ceS2 && !core.oscS2) begin
      next_core.oscHalt = 1'b1;
    end
    // The alarm flag is a plain level, so a write to its bit has no effect.
    next_core.alarmFlag = alarmEnable && alarmMatch;
    if (wrPer) begin
      next_core.period = wr.data;
    end
    // Pulse mode shapes the flag from the prescaler; level mode keeps it sticky.
    if (!core.period[BIT_MODE]) begin
      case (core.period[1:0])
        2'h0: pulseLow = 1'b0;
        2'h1: pulseLow = 1'b1;
        2'h2: pulseLow = core.subSec[0];
        default: pulseLow = core.subSec[9];
      endcase
      next_core.irqFlag = pulseLow;
    end else begin
      if (wrCtrl) begin
        next_core.irqFlag = wr.data[BIT_FLAG];
      end
      if (doCarry && !doAdj && levelHit(core.period[2:0], next_core.tm)) begin
        next_core.irqFlag = 1'b1;
      end
    end
    // The pin enable follows the next flags, so pin and flags move in the same cycle.
    next_core.irqLow = next_core.alarmFlag || next_core.irqFlag;
  end

  // Core state register.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      core <= CORE_RST;
    end else begin
      core <= next_core;
    end
  end

  // The flag and busy bits are independent levels, so bitwise synchronising is safe for them; the period bits are one 4-bit register.
  assign statusVec = {core.period, core.irqFlag, core.alarmFlag, core.oscHalt, counterBusy};

  // ************************************************************
  // Link domain
  // ************************************************************

  // Frame logic restarts whenever chip enable drops; the serial clock may stop.
  assign frameRstN = rstn & chipEnable;

  // Shift the frame in; a read command loads the status snapshot for the data edges.
  always_comb begin
    next_frame = frame;
    next_frame.st1 = statusVec;
    next_frame.st2 = frame.st1;
    if (frame.bitCnt != FRAME_END) begin
      next_frame.bitCnt = frame.bitCnt + 4'h1;
    end
    next_frame.sh = {frame.sh[9:0], serialDataIoIn};
    if (frame.bitCnt == READ_BIT && {frame.sh[2:0], serialDataIoIn} == CMD_READ) begin
      next_frame.oe = 1'b1;
      // Bank select is not consulted for these two registers.
      if (frame.sh[6:3] == REG_CTRL1) begin
        next_frame.outSh = frame.st2[3:0];
      end else if (frame.sh[6:3] == REG_PERIOD) begin
        next_frame.outSh = frame.st2[7:4];
      end else begin
        next_frame.outSh = 4'h0;
      end
    end else if (frame.oe) begin
      next_frame.outSh = {frame.outSh[2:0], 1'b0};
      if (frame.bitCnt == LAST_BIT) begin
        next_frame.oe = 1'b0;
      end
    end
  end

  // Frame register; chip enable low clears it without a serial clock edge.
  always_ff @(posedge serialClock or negedge frameRstN) begin
    if (!frameRstN) begin
      frame <= '0;
    end else begin
      frame <= next_frame;
    end
  end

  // Completed write: hold address and data, toggle to signal the core.
  // Only the toggle is synchronised; address and data are read once it has settled.
  always_comb begin
    next_wr = wr;
    if (frame.bitCnt == LAST_BIT && frame.sh[6:3] == CMD_WRITE) begin
      next_wr.addr = frame.sh[10:7];
      next_wr.data = {frame.sh[2:0], serialDataIoIn};
      next_wr.tgl  = ~wr.tgl;
    end
  end

  // The held word stays stable for a whole frame, far longer than the crossing.
  always_ff @(posedge serialClock or negedge rstn) begin
    if (!rstn) begin
      wr <= '0;
    end else begin
      wr <= next_wr;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************

  // Interrupt pin is open-drain: the value is always low, only the enable moves.
  // The released interrupt level comes from a pull-up outside, so that pin never drives high.
  assign irqOutN         = 1'b0;
  assign irqOutNOeN      = ~core.irqLow;
  assign serialDataIoOut = frame.outSh[3];
  assign serialDataIoOeN = ~frame.oe;
  assign timeNow         = core.tm;
endmodule : rtccp_top

`default_nettype wire

// File: hdl/rtccp_pkg.sv
// Purpose: Constants and carrier types for the RTC control and periodic interrupt block.
// Assumes: Core clock of 125 MHz; serial link clocked by its own serial clock.
// Notes:   Times are kept in their own units and converted to cycle counts here.
package rtccp_pkg;
  localparam int CLK_HZ        = 125_000_000;
  localparam int CLK_PERIOD_NS = 8;
  localparam int HALF_TICK_HZ  = 2048;
  localparam int HALF_TICK_CYC = CLK_HZ / HALF_TICK_HZ;
  localparam int BUSY_MAX_NS   = 122100;
  localparam int BUSY_CYC      = BUSY_MAX_NS / CLK_PERIOD_NS;

  localparam logic [3:0] REG_PERIOD = 4'h7;
  localparam logic [3:0] REG_CTRL1  = 4'hE;
  localparam logic [3:0] CMD_WRITE  = 4'h8;
  localparam logic [3:0] CMD_READ   = 4'hC;
  localparam logic [3:0] READ_BIT   = 4'h7;
  localparam logic [3:0] LAST_BIT   = 4'hB;
  localparam logic [3:0] FRAME_END  = 4'hC;

  localparam int BIT_ADJ  = 0;
  localparam int BIT_HOLD = 1;
  localparam int BIT_FLAG = 3;
  localparam int BIT_MODE = 3;

  localparam logic [3:0] PERIOD_RST = 4'h0;
  localparam logic       HOLD_RST   = 1'b1;
  localparam logic       HALT_RST   = 1'b1;

  localparam logic [5:0]  SEC_MAX     = 6'h3B;
  localparam logic [5:0]  SEC_HALF    = 6'h1E;
  localparam logic [5:0]  MIN_MAX     = 6'h3B;
  localparam logic [5:0]  TEN         = 6'h0A;
  localparam logic [4:0]  HOUR_MAX    = 5'h17;
  localparam logic [2:0]  WDAY_MAX    = 3'h6;
  localparam logic [4:0]  MDAY_MAX    = 5'h1F;
  localparam logic [4:0]  MDAY_FIRST  = 5'h01;
  localparam logic [10:0] SUBSEC_LAST = 11'h7FF;

  typedef struct packed {
    logic [5:0] sec;
    logic [5:0] min;
    logic [4:0] hour;
    logic [2:0] wday;
    logic [4:0] mday;
  } rtccp_time_t;

  localparam rtccp_time_t TIME_RST = '{6'h00, 6'h00, 5'h00, 3'h0, 5'h01};
endpackage : rtccp_pkg

// File: test/rtccp_asserts.sv
// Purpose: Port-level checker for rtccp_top.
// Assumes: Bench parameters shorten the half tick.
// Notes:   Bound to the design after the module.
`timescale 1ns/100ps
`default_nettype none
// ****
// Checker
// ****
module rtccp_asserts (
  input wire logic                  clock,
  input wire logic                  rstn,
  input wire logic                  serialClock,
  input wire logic                  chipEnable,
  input wire logic                  serialDataIoOeN,
  input wire logic                  irqOutN,
  input wire logic                  irqOutNOeN,
  input wire logic                  alarmEnable,
  input wire logic                  alarmMatch,
  input wire rtccp_pkg::rtccp_time_t timeNow
);
  import rtccp_pkg::*;
  logic [3:0] edgeCnt;
  // Link edges in this frame; chip enable low starts the next frame afresh.
  always_ff @(posedge serialClock or negedge chipEnable) begin
    if (!chipEnable) begin
      edgeCnt <= 4'h0;
    end else if (edgeCnt != 4'hF) begin
      edgeCnt <= edgeCnt + 4'h1;
    end
  end
  rst_values_a: assert property (@(posedge clock) disable iff (!rstn)
    $rose(rstn) |-> irqOutNOeN && timeNow == TIME_RST) else $error("reset values wrong");
  pin_low_a: assert property (@(posedge clock) disable iff (!rstn)
    irqOutN == 1'b0) else $error("irq pin value not low");
  alarm_irq_a: assert property (@(posedge clock) disable iff (!rstn)
    alarmEnable && alarmMatch |-> ##[1:3] !irqOutNOeN) else $error("alarm left irq released");
  sec_step_a: assert property (@(posedge clock) disable iff (!rstn)
    $changed(timeNow.sec) |-> timeNow.sec == $past(timeNow.sec) + 6'h01 || timeNow.sec == 6'h00)
    else $error("seconds jumped");
  min_at_zero_a: assert property (@(posedge clock) disable iff (!rstn)
    $changed(timeNow.min) |-> timeNow.sec == 6'h00) else $error("minute moved off second zero");
  adj_round_up_a: assert property (@(posedge clock) disable iff (!rstn)
    timeNow.sec == 6'h00 && $past(timeNow.sec) >= SEC_HALF |-> timeNow.min != $past(timeNow.min))
    else $error("minute not advanced");
  adj_keep_min_a: assert property (@(posedge clock) disable iff (!rstn)
    timeNow.sec == 6'h00 && $past(timeNow.sec) != 6'h00 && $past(timeNow.sec) < SEC_HALF
    |-> $stable(timeNow.min)) else $error("minute moved on early adjust");
  read_oe_late_a: assert property (@(posedge serialClock) disable iff (!rstn)
    edgeCnt < 4'h8 |-> serialDataIoOeN) else $error("data driven before command done");
endmodule : rtccp_asserts
bind rtccp_top rtccp_asserts u_asserts (.clock(clock), .rstn(rstn), .serialClock(serialClock),
  .chipEnable(chipEnable), .serialDataIoOeN(serialDataIoOeN), .irqOutN(irqOutN),
  .irqOutNOeN(irqOutNOeN), .alarmEnable(alarmEnable), .alarmMatch(alarmMatch), .timeNow(timeNow));
`default_nettype wire

// File: test/rtccp_host.sv
// Purpose: Host model driving the three-wire link.
// Assumes: Link clock period 48 ns, still outside frames.
// Notes:   A frame may leave chip enable high on request.
`timescale 1ns/100ps
`default_nettype none
// ****
// Host
// ****
module rtccp_host (
  input  wire logic serialDataIoOut,
  input  wire logic serialDataIoOeN,
  output logic      serialClock,
  output logic      chipEnable,
  output wire logic serialDataIoIn
);
  import rtccp_pkg::*;
  logic hostBit;
  logic hostDrive;
  // A released wire shows the inverse of the last bit, so stale data never reads right.
  assign serialDataIoIn = !serialDataIoOeN ? serialDataIoOut : (hostDrive ? hostBit : !hostBit);
  // Idle link at time zero.
  initial begin
    serialClock = 1'b0;
    chipEnable = 1'b0;
    hostBit = 1'b0;
    hostDrive = 1'b1;
  end
  // Frames carry any address and drop chip enable promptly unless keep is set.
  task automatic frame(input logic [11:0] bits, input logic keep, output logic [3:0] rd);
    int i;
    rd = 4'h0;
    #3.7 chipEnable = 1'b1;
    for (i = 11; i >= 0; i--) begin
      hostDrive = (i > 3) || (bits[7:4] != CMD_READ);
      hostBit = bits[i];
      #24 serialClock = 1'b1;
      #24 serialClock = 1'b0;
      if (i >= 1 && i <= 4) rd[i-1] = serialDataIoIn;
    end
    hostDrive = 1'b1;
    if (!keep) endHold();
  endtask : frame
  // Ends a frame; the gap keeps writes a microsecond apart.
  task automatic endHold();
    #24 chipEnable = 1'b0;
    #1000;
  endtask : endHold
endmodule : rtccp_host
`default_nettype wire

// File: test/rtccp_top_test.sv
// Purpose: Register-level tests of rtccp_top.
// Assumes: One second is 2048 cycles at HALF_TICK 1.
// Notes:   Busy shortened to 400 cycles, still long enough for a read frame to see it.
`timescale 1ns/100ps
`default_nettype none
// ****
// Testbench
// ****
module rtccp_top_test;
  import rtccp_pkg::*;
  logic        clock = 1'b0;
  logic        rstn = 1'b0;
  logic        oscRunning = 1'b1;
  logic        alarmEnable = 1'b0;
  logic        alarmMatch = 1'b0;
  wire         serialClock;
  wire         chipEnable;
  wire         serialDataIoIn;
  logic        serialDataIoOut;
  logic        serialDataIoOeN;
  logic        irqOutN;
  logic        irqOutNOeN;
  rtccp_time_t timeNow;
  logic [5:0]  s;
  int          i;
  int          n_errors = 0;
  int          samples_checked = 0;
  // Core clock, 8 ns period.
  always #4 clock = ~clock;
  rtccp_top #(.HALF_TICK(1), .BUSY_LEN(400)) u_dut (.clock(clock), .rstn(rstn),
    .serialClock(serialClock), .chipEnable(chipEnable), .serialDataIoIn(serialDataIoIn),
    .serialDataIoOut(serialDataIoOut), .serialDataIoOeN(serialDataIoOeN), .oscRunning(oscRunning),
    .alarmEnable(alarmEnable), .alarmMatch(alarmMatch), .irqOutN(irqOutN),
    .irqOutNOeN(irqOutNOeN), .timeNow(timeNow));
  rtccp_host u_host (.serialDataIoOut(serialDataIoOut), .serialDataIoOeN(serialDataIoOeN),
    .serialClock(serialClock), .chipEnable(chipEnable), .serialDataIoIn(serialDataIoIn));
  // Core inputs change one nanosecond after the edge, clear of sampling.
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : cyc
  task automatic check(input string name, input logic [24:0] seen, input logic [24:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [3:0] addr, input logic [3:0] data, input logic keep);
    logic [3:0] v;
    u_host.frame({addr, CMD_WRITE, data}, keep, v);
    cyc(1);
  endtask : wr
  task automatic rd(input string name, input logic [3:0] addr, input logic [3:0] mask,
                    input logic [3:0] exp);
    logic [3:0] v;
    u_host.frame({addr, CMD_READ, 4'h0}, 1'b0, v);
    cyc(1);
    check(name, v & mask, exp);
  endtask : rd
  // Low cycles of the interrupt over a window of whole periods.
  task automatic countLow(input string name, input int n, input int exp);
    int k;
    k = 0;
    repeat (n) begin
      cyc(1);
      if (irqOutNOeN === 1'b0) k++;
    end
    check(name, 25'(k), 25'(exp));
  endtask : countLow
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : summarize
  // Main sequence; reads mask busy wherever a second carry may overlap.
  initial begin
    cyc(10);
    rstn = 1'b1;
    cyc(2);
    check("irqOe", irqOutNOeN, 1'b1);
    check("sioOe", serialDataIoOeN, 1'b1);
    check("time", timeNow, TIME_RST);
    rd("ctrlRst", REG_CTRL1, 4'hE, 4'h2);
    rd("perRst", REG_PERIOD, 4'hF, PERIOD_RST);
    wr(REG_CTRL1, 4'h2, 1'b0);
    rd("haltClr", REG_CTRL1, 4'hE, 4'h0);
    oscRunning = 1'b0;
    cyc(10);
    oscRunning = 1'b1;
    rd("haltSet", REG_CTRL1, 4'hE, 4'h2);
    $display("test reset and halt done");
    s = timeNow.sec;
    for (i = 0; i < 2100 && timeNow.sec === s; i++) cyc(1);
    s = timeNow.sec;
    wr(REG_CTRL1, 4'h0, 1'b1);
    oscRunning = 1'b0;
    cyc(10);
    oscRunning = 1'b1;
    cyc(2100);
    check("secHeld", timeNow.sec, s);
    u_host.endHold();
    cyc(1);
    check("secCarry", timeNow.sec, s + 6'h01);
    rd("haltKeep", REG_CTRL1, 4'hE, 4'h0);
    wr(REG_CTRL1, 4'h3, 1'b0);
    check("adjSec", timeNow.sec, 6'h00);
    check("adjMin", timeNow.min, 6'h00);
    rd("busyOn", REG_CTRL1, 4'h1, 4'h1);
    cyc(450);
    rd("busyOff", REG_CTRL1, 4'h1, 4'h0);
    wr(4'h3, 4'hF, 1'b0);
    rd("badAddr", 4'h3, 4'hF, 4'h0);
    rd("perKeep", REG_PERIOD, 4'hF, 4'h0);
    $display("test hold and adjust done");
    wr(REG_PERIOD, 4'h8, 1'b0);
    rd("perLvl", REG_PERIOD, 4'hF, 4'h8);
    for (i = 0; i < 2100 && irqOutNOeN === 1'b1; i++) cyc(1);
    check("lvlSec", irqOutNOeN, 1'b0);
    wr(REG_CTRL1, 4'h2, 1'b0);
    check("flagOff", irqOutNOeN, 1'b1);
    wr(REG_CTRL1, 4'hA, 1'b0);
    check("flagOn", irqOutNOeN, 1'b0);
    rd("flagRd", REG_CTRL1, 4'h8, 4'h8);
    wr(REG_CTRL1, 4'h2, 1'b0);
    wr(REG_PERIOD, 4'h0, 1'b0);
    wr(REG_CTRL1, 4'hA, 1'b0);
    check("pulseOff", irqOutNOeN, 1'b1);
    wr(REG_PERIOD, 4'h1, 1'b0);
    check("pulseLow", irqOutNOeN, 1'b0);
    rd("pulseFlag", REG_CTRL1, 4'h8, 4'h8);
    wr(REG_PERIOD, 4'h2, 1'b0);
    countLow("sqFast", 256, 128);
    wr(REG_PERIOD, 4'h3, 1'b0);
    countLow("sqHalf", 2048, 1024);
    wr(REG_PERIOD, 4'h0, 1'b0);
    $display("test interrupt modes done");
    alarmEnable = 1'b1;
    alarmMatch = 1'b1;
    cyc(4);
    check("almIrq", irqOutNOeN, 1'b0);
    rd("almFlag", REG_CTRL1, 4'h4, 4'h4);
    alarmMatch = 1'b0;
    cyc(4);
    check("almOff", irqOutNOeN, 1'b1);
    rd("almClr", REG_CTRL1, 4'h4, 4'h0);
    wr(REG_PERIOD, 4'h9, 1'b0);
    for (i = 0; i < 21000 && irqOutNOeN === 1'b1; i++) cyc(1);
    check("lvlTenLow", irqOutNOeN, 1'b0);
    check("lvlTenSec", timeNow.sec % TEN, 6'h00);
    wr(REG_CTRL1, 4'h2, 1'b0);
    check("lvlTenClr", irqOutNOeN, 1'b1);
    wr(REG_PERIOD, 4'h0, 1'b0);
    for (i = 0; i < 70000 && timeNow.sec !== 6'h1F; i++) cyc(1);
    wr(REG_CTRL1, 4'h1, 1'b1);
    cyc(40);
    check("adjWait", timeNow.sec, 6'h1F);
    u_host.endHold();
    cyc(1);
    check("adjUpSec", timeNow.sec, 6'h00);
    check("adjUpMin", timeNow.min, 6'h01);
    $display("test alarm and deferred adjust done");
    summarize();
  end
  // The sequence needs about 70000 cycles; a hang ends here.
  initial begin
    repeat (90000) @(posedge clock);
    n_errors++;
    summarize();
  end
endmodule : rtccp_top_test
`default_nettype wire
